/* File: logic/pirq_defines.vh */
// Register offsets, field positions and reset values of the interrupt/loopback/diag bank
`ifndef PIRQ_DEFINES_VH
`define PIRQ_DEFINES_VH

`define PIRQ_ADDR_W          5
`define PIRQ_OFS_INT_CTRL    5'h1B
`define PIRQ_OFS_FUNC_CTRL   5'h1C
`define PIRQ_OFS_CABLE_DIAG  5'h1D

`define PIRQ_INT_EN_HI       15
`define PIRQ_INT_EN_LO       8
`define PIRQ_INT_FLAG_HI     7
`define PIRQ_INT_FLAG_LO     0
`define PIRQ_INT_EN_RST      8'h00

`define PIRQ_FC_LOOP_BIT     5
`define PIRQ_FC_RST          16'h0010

`define PIRQ_CD_START_BIT    15
`define PIRQ_CD_RES_HI       14
`define PIRQ_CD_RES_LO       13
`define PIRQ_CD_SHORT_BIT    12
`define PIRQ_CD_RSVD_HI      11
`define PIRQ_CD_RSVD_LO      9
`define PIRQ_CD_RSVD_RST     3'h0

`define PIRQ_RES_NORMAL      2'h0
`define PIRQ_RES_OPEN        2'h1
`define PIRQ_RES_SHORT       2'h2
`define PIRQ_RES_FAIL        2'h3

`endif

/* File: logic/pirq_regs.v */
// Interrupt, function control and cable diagnostic register logic of a 10/100 PHY
// Behaviour
// [R01] Bits 11..8 of the interrupt register are read-write enables for partner ack, link down, remote fault and link up, reset zero.
// [R02] Bits 7 and 6 latch jabber and receive error events, read-only, reset zero, cleared by a read.
// [R03] Bits 5 and 4 latch page received and parallel detect fault events, read-only, reset zero, cleared by a read.
// [R04] Bits 3 and 2 latch partner ack and link down events, read-only, reset zero, cleared by a read.
// [R05] Bits 1 and 0 latch remote fault and link up events, read-only, reset zero, cleared by a read.
// [R06] Bits 15..12 are read-write enables for jabber, receive error, page received and parallel detect fault, reset zero.
// [R07] The interrupt output is active while any flag is set with its enable set.
// [R08] Function control bit 5 selects local loopback, which acts only with the basic control loopback bit also set.
// [R09] Writing one to cable diag bit 15 starts the test and the bit clears itself when the test finishes.
// [R10] The host treats the result fields as valid only after reading bit 15 back as zero.
// [R11] Cable diag bits 14..13 report 00 normal, 01 open, 10 short, 11 failed, reset 00.
// [R12] Cable diag bit 12 is set when a cable shorter than ten metres is detected, reset zero.
`timescale 1ns/100ps
`include "pirq_defines.vh"

module pirq_regs (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // Management register access
  input  wire [4:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  // Event pulses from link, AN and receive engines, order matches flag bits 7..0
  input  wire [7:0]  evt_in,
  // Loopback control
  input  wire        basic_loopback,
  output wire        local_loopback_en,
  // Cable test engine
  output reg         cable_test_start,
  input  wire        cable_test_done,
  input  wire [1:0]  cable_test_result,
  input  wire        cable_test_short,
  // Interrupt output
  output wire        irq_n
);

  reg  [7:0]  int_en_r;
  reg  [7:0]  int_flag_r;
  reg  [7:0]  int_flag_nxt;
  reg  [15:0] func_ctrl_r;
  reg         cd_busy_r;
  reg  [1:0]  cd_result_r;
  reg         cd_short_r;
  reg  [2:0]  cd_rsvd_r;

  wire wr_int = reg_wr && (reg_addr == `PIRQ_OFS_INT_CTRL);
  wire rd_int = reg_rd && (reg_addr == `PIRQ_OFS_INT_CTRL);
  wire wr_fc  = reg_wr && (reg_addr == `PIRQ_OFS_FUNC_CTRL);
  wire wr_cd  = reg_wr && (reg_addr == `PIRQ_OFS_CABLE_DIAG);
  wire cd_go  = wr_cd && reg_wdata[`PIRQ_CD_START_BIT] && !cd_busy_r;

  // Interrupt enables
  always @(posedge core_clk) begin
    if (!rst_n) begin
      int_en_r <= `PIRQ_INT_EN_RST; // [R01] [R06]
    end else if (wr_int) begin
      int_en_r <= reg_wdata[`PIRQ_INT_EN_HI:`PIRQ_INT_EN_LO]; // [R01] [R06]
    end
  end

  // Read clears flags, but an event in the same cycle survives the clear
  always @* begin
    int_flag_nxt = int_flag_r;
    if (rd_int) begin
      int_flag_nxt = 8'h00;
    end
    int_flag_nxt = int_flag_nxt | evt_in; // [R02] [R03] [R04] [R05]
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      int_flag_r <= 8'h00;
    end else begin
      int_flag_r <= int_flag_nxt; // [R02] [R03] [R04] [R05]
    end
  end

  // Enable bit n+8 gates flag bit n
  assign irq_n = ~|(int_flag_r & int_en_r); // [R07]

  // Function control; reserved bits keep their written value
  always @(posedge core_clk) begin
    if (!rst_n) begin
      func_ctrl_r <= `PIRQ_FC_RST;
    end else if (wr_fc) begin
      func_ctrl_r <= reg_wdata;
    end
  end

  assign local_loopback_en = func_ctrl_r[`PIRQ_FC_LOOP_BIT] & basic_loopback; // [R08]

  // Cable diagnostic: results update only when the engine reports done
  always @(posedge core_clk) begin
    if (!rst_n) begin
      cd_busy_r        <= 1'b0;
      cable_test_start <= 1'b0;
      cd_result_r      <= `PIRQ_RES_NORMAL;
      cd_short_r       <= 1'b0;
      cd_rsvd_r        <= `PIRQ_CD_RSVD_RST;
    end else begin
      cable_test_start <= cd_go; // [R09]
      if (wr_cd) begin
        cd_rsvd_r <= reg_wdata[`PIRQ_CD_RSVD_HI:`PIRQ_CD_RSVD_LO];
      end
      if (cd_go) begin
        cd_busy_r <= 1'b1; // [R09]
      end else if (cd_busy_r && cable_test_done) begin
        cd_busy_r   <= 1'b0; // [R09] [R10]
        cd_result_r <= cable_test_result; // [R11]
        cd_short_r  <= cable_test_short; // [R12]
      end
    end
  end

  // Read data, registered; unmapped offsets read zero
  always @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `PIRQ_OFS_INT_CTRL:   reg_rdata <= {int_en_r, int_flag_r};
        `PIRQ_OFS_FUNC_CTRL:  reg_rdata <= func_ctrl_r;
        `PIRQ_OFS_CABLE_DIAG: reg_rdata <= {cd_busy_r, cd_result_r, cd_short_r,
                                            cd_rsvd_r, 9'h000};
        default:              reg_rdata <= 16'h0000;
      endcase
    end
  end

endmodule // pirq_regs

/* File: dv/pirq_engine_model.sv */
// Cable test engine stand-in: answers each start after a fixed delay
`timescale 1ns/100ps
module pirq_engine_model(input wire core_clk, cable_test_start, sh, input wire [1:0] res,
  output reg cable_test_done = 0, output reg [1:0] cable_test_result = 0,
  output reg cable_test_short = 0);
  integer cnt = 0;
  always @(posedge core_clk) begin
    cable_test_done <= cnt == 1;
    // Outcome lines carry junk outside the done pulse
    {cable_test_result, cable_test_short} <= cnt == 1 ? {res, sh} : ~{res, sh};
    cnt <= cable_test_start ? 6 : cnt > 0 ? cnt - 1 : 0;
  end
endmodule // pirq_engine_model

/* File: dv/pirq_checker.sv */
// Port-level assertions for the interrupt, loopback and cable diag registers
`timescale 1ns/100ps
module pirq_checker(input wire core_clk, rst_n, reg_wr, reg_rd, basic_loopback,
  input wire [4:0] reg_addr, input wire [15:0] reg_wdata, reg_rdata, input wire [7:0] evt_in,
  input wire local_loopback_en, cable_test_start, cable_test_done, irq_n);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire rd_int = reg_rd && reg_addr == 5'h1B;
  a_start_pulse: assert property (cable_test_start |=> !cable_test_start)
    else $error("start width");
  a_start_cause: assert property ($rose(cable_test_start) |->
    $past(reg_wr && reg_addr == 5'h1D && reg_wdata[15])) else $error("start cause");
  a_busy_read: assert property ($past(cable_test_start) && reg_rd && reg_addr == 5'h1D
    && !cable_test_done |=> reg_rdata[15]) else $error("busy bit");
  a_loop_and: assert property (basic_loopback && $past(reg_wr && reg_addr == 5'h1C) |->
    local_loopback_en == $past(reg_wdata[5])) else $error("loopback");
  // Enabling an already set flag also drops the line
  a_irq_cause: assert property ($fell(irq_n) |->
    $past(evt_in != 8'h00 || (reg_wr && reg_addr == 5'h1B))) else $error("irq cause");
  a_irq_clear: assert property (rd_int && evt_in == 8'h00 |=> irq_n) else $error("irq");
  a_flag_set: assert property (evt_in[7] ##1 !rd_int ##1 rd_int |=> reg_rdata[7])
    else $error("flag");
  a_en_readback: assert property (reg_wr && reg_addr == 5'h1B ##1 !reg_wr ##1 rd_int
    |=> reg_rdata[15:8] == $past(reg_wdata[15:8], 3)) else $error("enables");
endmodule // pirq_checker
bind pirq_regs pirq_checker u_chk(.*);

/* File: dv/pirq_regs_tb_top.sv */
// Self-checking bench for the interrupt, loopback and cable diag registers
`timescale 1ns/100ps
module pirq_regs_tb_top;
  reg core_clk=0, rst_n=0, reg_wr=0, reg_rd=0, basic_loopback=0, sh=0;
  reg [4:0] reg_addr=0; reg [15:0] reg_wdata=0; reg [7:0] evt_in=0; reg [1:0] res=0;
  wire [15:0] reg_rdata; wire [1:0] cable_test_result;
  wire local_loopback_en, cable_test_start, cable_test_done, cable_test_short, irq_n;
  integer fail_count=0, samples_checked=0, cyc=0, i, n;
  pirq_regs DUT(.*);
  pirq_engine_model ENG(.*);
  initial forever #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc > 3000) begin fail_count++; report_and_stop; end
  task chk(string s, input [15:0] e, g);
    samples_checked++;
    if (g !== e) begin fail_count++; $display("unexpected %s expected %h seen %h", s, e, g); end
  endtask
  task wr(input [4:0] a, input [15:0] d);
    @(negedge core_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge core_clk) reg_wr = 0;
  endtask
  task rd(input [4:0] a);
    @(negedge core_clk) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge core_clk) reg_rd = 0;
  endtask
  task t_reset;
    rd(5'h1B); chk("int", 16'h0000, reg_rdata);
    rd(5'h1C); chk("func", 16'h0010, reg_rdata);
    rd(5'h1D); chk("diag", 16'h0000, reg_rdata);
    rd(5'h00); chk("unmapped", 16'h0000, reg_rdata);
  endtask
  task t_int;
    for (i = 0; i < 8; i++) begin
      wr(5'h1B, 16'h0100 << i);
      rd(5'h1B); chk("enables", {8'h01 << i, 8'h00}, reg_rdata);
      @(negedge core_clk) evt_in = ~(8'h01 << i);
      @(negedge core_clk) evt_in = 0; chk("irq", 1, irq_n);
      rd(5'h1B); chk("flags", {8'h01 << i, ~(8'h01 << i)}, reg_rdata);
      evt_in = 8'h01 << i;
      @(negedge core_clk) evt_in = 0; chk("irq", 0, irq_n);
      rd(5'h1B); chk("flags", {8'h01 << i, 8'h01 << i}, reg_rdata);
      chk("irq", 1, irq_n);
    end
  endtask
  task t_loop;
    wr(5'h1C, 16'h0020); chk("loop", 0, local_loopback_en);
    basic_loopback = 1; #1 chk("loop", 1, local_loopback_en);
    wr(5'h1C, 16'h0010); chk("loop", 0, local_loopback_en);
  endtask
  task t_cable;
    for (i = 0; i < 4; i++) begin
      {res, sh} = {i[1:0], i[0]}; wr(5'h1D, 16'h8000); n = 0;
      do begin rd(5'h1D); n++; end while (reg_rdata[15] === 1'b1 && n < 50);
      chk("busy", 1, n > 1);
      chk("diag", {1'b0, i[1:0], i[0], 12'h000}, reg_rdata);
    end
  endtask
  task report_and_stop;
    if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge core_clk); rst_n = 1;
    t_reset; t_int; t_loop; t_cable; report_and_stop;
  end
endmodule // pirq_regs_tb_top
